//--- rtl/fbcp_host.v
// Host controller that drives a parallel NOR flash through its pins.
// Assumes an AHB-Lite master on the register side and a pull-up on the
// flash busy status line, so an idle device reads high.
//
// Chosen here: the address map and the AHB-Lite register port.
`default_nettype none
`include "fbcp_consts.vh"

module fbcp_host
(
  input  wire                    mclk,
  input  wire                    reset,
  input  wire                    hsel,
  input  wire [31:0]             haddr,
  input  wire [1:0]              htrans,
  input  wire                    hwrite,
  input  wire [2:0]              hsize,
  input  wire                    hready,
  input  wire [31:0]             hwdata,
  output reg  [31:0]             hrdata,
  output wire                    hreadyout,
  output wire                    hresp,
  output wire                    irq,
  output reg                     chip_select_0,
  output wire                    chip_select_1,
  output wire                    chip_select_2,
  output reg                     oe_n,
  output reg                     we_n,
  output reg                     reset_powerdown_n,
  output reg                     byte_wide,
  output reg                     program_enable_supply,
  output reg  [`FBCP_AW-1:0]     addr,
  output reg  [`FBCP_DW-1:0]     dq_o,
  output reg                     dq_oe,
  input  wire [`FBCP_DW-1:0]     dq_i,
  input  wire                    busy_status_output
);

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_SETUP = 6'h02;
  localparam [5:0] ST_STRB  = 6'h04;
  localparam [5:0] ST_HOLD  = 6'h08;
  localparam [5:0] ST_RST   = 6'h10;
  localparam [5:0] ST_WAKE  = 6'h20;

  // Counts are worked out as integers, then cut to the counter width
  localparam integer N_SETUP = `FBCP_CYC(`FBCP_T_SETUP_NS);
  localparam integer N_STRB  = `FBCP_CYC(`FBCP_T_STRB_NS);
  localparam integer N_HOLD  = `FBCP_CYC(`FBCP_T_HOLD_NS);
  localparam integer N_RST   = `FBCP_CYC(`FBCP_T_RST_NS);
  localparam integer N_WAKE  = `FBCP_CYC(`FBCP_T_WAKE_NS);
  localparam [11:0]  C_SETUP = N_SETUP[11:0];
  localparam [11:0]  C_STRB  = N_STRB[11:0];
  localparam [11:0]  C_HOLD  = N_HOLD[11:0];
  localparam [11:0]  C_RST   = N_RST[11:0];
  localparam [11:0]  C_WAKE  = N_WAKE[11:0];

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  reg                     wr_q;
  reg  [7:0]              wofs_q;
  reg  [`FBCP_CTRL_W-1:0] ctrl_q;
  reg  [`FBCP_AW-1:0]     addr_reg_q;
  reg  [`FBCP_DW-1:0]     wdata_q;
  reg  [`FBCP_DW-1:0]     rdata_q;
  reg  [`FBCP_IRQ_W-1:0]  irq_stat_q;
  reg  [`FBCP_IRQ_W-1:0]  irq_mask_q;
  reg  [5:0]              state_q;
  reg  [11:0]             cnt_q;
  reg                     busy_n_q;
  reg  [`FBCP_IRQ_W-1:0]  irq_ev;
  reg  [`FBCP_DW-1:0]     rd_cap;
  wire                    addr_ph;
  wire [7:0]              rofs;
  wire                    go;
  wire                    idle;
  wire                    cnt_end;
  wire                    is_write;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // Single part on the bus: the two extra selects are held enabling
  assign chip_select_1 = 1'b0;
  assign chip_select_2 = 1'b0;
  assign irq = |(irq_stat_q & irq_mask_q);

  assign addr_ph  = hsel & htrans[1] & hready;
  assign rofs     = haddr[7:0];
  assign idle     = (state_q == ST_IDLE);
  assign cnt_end  = (cnt_q == 12'h000);
  assign is_write = ctrl_q[`FBCP_CTRL_WRITE];
  // A start request while a cycle runs is ignored
  assign go = wr_q & hit(wofs_q, `FBCP_OFS_CTRL) & hwdata[`FBCP_CTRL_GO]
              & idle;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      wr_q   <= 1'b0;
      wofs_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_q   <= addr_ph & hwrite;
      wofs_q <= rofs;
      if (addr_ph & ~hwrite)
      begin
        if (hit(rofs, `FBCP_OFS_CTRL))
          hrdata <= {26'h0, ctrl_q};
        else if (hit(rofs, `FBCP_OFS_ADDR))
          hrdata <= {9'h0, addr_reg_q};
        else if (hit(rofs, `FBCP_OFS_WDATA))
          hrdata <= {16'h0, wdata_q};
        else if (hit(rofs, `FBCP_OFS_RDATA))
          hrdata <= {16'h0, rdata_q};
        else if (hit(rofs, `FBCP_OFS_STAT))
          hrdata <= {28'h0, ~reset_powerdown_n, busy_n_q, ~idle, 1'b0};
        else if (hit(rofs, `FBCP_OFS_IRQ_STAT))
          hrdata <= {29'h0, irq_stat_q};
        else if (hit(rofs, `FBCP_OFS_IRQ_MASK))
          hrdata <= {29'h0, irq_mask_q};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_q     <= 6'h00;
      addr_reg_q <= 23'h00_0000;
      wdata_q    <= 16'h0000;
      irq_mask_q <= 3'h0;
    end
    else if (wr_q)
    begin
      // Settings other than the interrupt mask are frozen while a cycle runs so pins stay stable
      if (hit(wofs_q, `FBCP_OFS_CTRL) & idle)
        ctrl_q <= {hwdata[`FBCP_CTRL_W-1:1], 1'b0};
      if (hit(wofs_q, `FBCP_OFS_ADDR) & idle)
        addr_reg_q <= hwdata[`FBCP_AW-1:0];
      if (hit(wofs_q, `FBCP_OFS_WDATA) & idle)
        wdata_q <= hwdata[`FBCP_DW-1:0];
      if (hit(wofs_q, `FBCP_OFS_IRQ_MASK))
        irq_mask_q <= hwdata[`FBCP_IRQ_W-1:0];
    end
  end

  // Sticky events, a write of one clears; a new event wins over the clear
  genvar g;
  generate
    for (g = 0; g < `FBCP_IRQ_W; g = g + 1)
    begin : g_irq
      always @(posedge mclk)
      begin
        if (reset)
          irq_stat_q[g] <= 1'b0;
        else if (irq_ev[g])
          irq_stat_q[g] <= 1'b1;
        else if (wr_q & hit(wofs_q, `FBCP_OFS_IRQ_STAT) & hwdata[g])
          irq_stat_q[g] <= 1'b0;
      end
    end
  endgenerate

  always @*
  begin
    irq_ev = 3'h0;
    irq_ev[`FBCP_IRQ_DONE]     = (state_q == ST_HOLD) & cnt_end;
    irq_ev[`FBCP_IRQ_BSY_END]  = busy_status_output & ~busy_n_q;
    irq_ev[`FBCP_IRQ_RST_DONE] = (state_q == ST_WAKE) & cnt_end;
  end

  // Read capture: narrow widths and busy status keep only valid lanes
  always @*
  begin
    rd_cap = dq_i;
    if (~byte_wide)
      rd_cap = {8'h00, dq_i[7:0]};
    if (ctrl_q[`FBCP_CTRL_IDENT])
      rd_cap = {8'h00, dq_i[7:0]};
    if (~busy_n_q)
      rd_cap = {8'h00, dq_i[`FBCP_ID_BIT], 7'h00};
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      state_q               <= ST_IDLE;
      cnt_q                 <= 12'h000;
      busy_n_q              <= 1'b1;
      rdata_q               <= 16'h0000;
      chip_select_0         <= 1'b1;
      oe_n                  <= 1'b1;
      we_n                  <= 1'b1;
      reset_powerdown_n     <= 1'b1;
      byte_wide             <= 1'b0;
      program_enable_supply <= 1'b0;
      addr                  <= 23'h00_0000;
      dq_o                  <= 16'h0000;
      dq_oe                 <= 1'b0;
    end
    else
    begin
      busy_n_q              <= busy_status_output;
      byte_wide             <= ctrl_q[`FBCP_CTRL_WORD];
      // Lockout level unless software asks to alter contents
      program_enable_supply <= ctrl_q[`FBCP_CTRL_PEN];
      if (~cnt_end)
        cnt_q <= cnt_q - 12'h001;
      case (state_q)
        ST_IDLE:
        begin
          if (go & hwdata[`FBCP_CTRL_RESET])
          begin
            reset_powerdown_n <= 1'b0;
            cnt_q             <= C_RST - 12'h001;
            state_q           <= ST_RST;
          end
          else if (go)
          begin
            chip_select_0 <= 1'b0;
            addr          <= addr_reg_q;
            if (hwdata[`FBCP_CTRL_IDENT])
              addr[0] <= 1'b0;
            dq_o          <= wdata_q;
            dq_oe         <= hwdata[`FBCP_CTRL_WRITE];
            cnt_q         <= C_SETUP - 12'h001;
            state_q       <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          if (cnt_end)
          begin
            // Only one strobe at a time
            we_n    <= ~is_write;
            oe_n    <= is_write;
            cnt_q   <= C_STRB - 12'h001;
            state_q <= ST_STRB;
          end
        end
        ST_STRB:
        begin
          if (cnt_end)
          begin
            // Write strobe rises with select still low, so it is the latch
            we_n    <= 1'b1;
            oe_n    <= 1'b1;
            if (~is_write)
              rdata_q <= rd_cap;
            cnt_q   <= C_HOLD - 12'h001;
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (cnt_end)
          begin
            chip_select_0 <= 1'b1;
            dq_oe         <= 1'b0;
            state_q       <= ST_IDLE;
          end
        end
        ST_RST:
        begin
          if (cnt_end)
          begin
            reset_powerdown_n <= 1'b1;
            cnt_q             <= C_WAKE - 12'h001;
            state_q           <= ST_WAKE;
          end
        end
        ST_WAKE:
        begin
          // No access until the part has woken in read array mode
          if (cnt_end)
            state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- inc/fbcp_consts.vh
// Constants for the parallel flash command port host controller.
// Assumes a 100 MHz mclk and a 32-bit AHB-Lite register port.
`ifndef FBCP_CONSTS_VH
`define FBCP_CONSTS_VH

// Register byte offsets
`define FBCP_OFS_CTRL     8'h00
`define FBCP_OFS_ADDR     8'h04
`define FBCP_OFS_WDATA    8'h08
`define FBCP_OFS_RDATA    8'h0c
`define FBCP_OFS_STAT     8'h10
`define FBCP_OFS_IRQ_STAT 8'h14
`define FBCP_OFS_IRQ_MASK 8'h18

// Control register fields
`define FBCP_CTRL_GO      0
`define FBCP_CTRL_WRITE   1
`define FBCP_CTRL_IDENT   2
`define FBCP_CTRL_WORD    3
`define FBCP_CTRL_PEN     4
`define FBCP_CTRL_RESET   5
`define FBCP_CTRL_W       6

// Interrupt bits
`define FBCP_IRQ_DONE     0
`define FBCP_IRQ_BSY_END  1
`define FBCP_IRQ_RST_DONE 2
`define FBCP_IRQ_W        3

// Widths
`define FBCP_AW           23
`define FBCP_DW           16
`define FBCP_ID_BIT       7

// Times in ns, cycles derived with round-up
`define FBCP_CLK_NS       10
`define FBCP_T_SETUP_NS   20
`define FBCP_T_STRB_NS    150
`define FBCP_T_HOLD_NS    20
`define FBCP_T_RST_NS     25000
`define FBCP_T_WAKE_NS    1000
`define FBCP_CYC(ns) (((ns) + `FBCP_CLK_NS - 1) / `FBCP_CLK_NS)

`endif

//--- sim/fbcp_host_chk.sv
// Pin timing checker for the flash host controller.
// Bound into every fbcp_host; sees only its ports.
`default_nettype none
`include "fbcp_consts.vh"
module fbcp_host_chk (
  input wire logic                mclk,
  input wire logic                reset,
  input wire logic                chip_select_0,
  input wire logic                chip_select_1,
  input wire logic                chip_select_2,
  input wire logic                oe_n,
  input wire logic                we_n,
  input wire logic                reset_powerdown_n,
  input wire logic [`FBCP_AW-1:0] addr,
  input wire logic [`FBCP_DW-1:0] dq_o,
  input wire logic                dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] pd_cnt_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Reset pulse is too long to unroll, so count it
  always @(posedge mclk)
    if (reset || reset_powerdown_n)
      pd_cnt_q <= 12'h0;
    else
      pd_cnt_q <= pd_cnt_q + 12'h1;
  AST_NO_OVERLAP: assert property (oe_n || we_n)
    else $error("both strobes low");
  AST_CS_FIXED: assert property (!chip_select_1 && !chip_select_2)
    else $error("extra selects not low");
  AST_WE_SEL: assert property (!we_n |-> !chip_select_0)
    else $error("write strobe while deselected");
  AST_WE_LEN: assert property ($fell(we_n) |-> ##14 !we_n ##1 we_n)
    else $error("write strobe width wrong");
  AST_LATCH: assert property ($rose(we_n) |->
    (!chip_select_0 && dq_oe && $stable(addr) && $stable(dq_o))
    ##2 chip_select_0)
    else $error("write data not held at strobe rise");
  AST_CYCLE: assert property ($fell(chip_select_0) |->
    (oe_n && we_n) ##2 !(oe_n && we_n) ##16 !chip_select_0 ##1
    chip_select_0)
    else $error("bus cycle shape wrong");
  AST_NO_FIGHT: assert property (dq_oe |-> oe_n && !chip_select_0)
    else $error("data driven during read or idle");
  AST_PD_QUIET: assert property (!reset_powerdown_n |->
    chip_select_0 && oe_n && we_n && !dq_oe)
    else $error("bus active during reset pulse");
  AST_PD_LEN: assert property ($rose(reset_powerdown_n) |->
    pd_cnt_q == 12'h9c4)
    else $error("reset pulse length wrong");
  C_WR: cover property ($rose(we_n));
  C_RD: cover property ($rose(oe_n));
  C_PD: cover property ($rose(reset_powerdown_n));
endmodule
bind fbcp_host fbcp_host_chk i_chk (.mclk(mclk), .reset(reset),
  .chip_select_0(chip_select_0), .chip_select_1(chip_select_1),
  .chip_select_2(chip_select_2), .oe_n(oe_n), .we_n(we_n),
  .reset_powerdown_n(reset_powerdown_n), .addr(addr), .dq_o(dq_o),
  .dq_oe(dq_oe));
`default_nettype wire

//--- sim/fbcp_flash_mdl.sv
// Behavioural parallel flash: array, identifier, status, program.
// Assumes the bench resolves the data wire from drv and a toggling pattern.
`default_nettype none
`include "fbcp_consts.vh"
module fbcp_flash_mdl #(
  parameter logic [7:0] MK = 8'h5a, // Arbitrary value
  parameter logic [7:0] PT = 8'h3c  // Arbitrary value
) (
  input wire logic                 cs0,
  input wire logic                 cs1,
  input wire logic                 cs2,
  input wire logic                 oe_n,
  input wire logic                 we_n,
  input wire logic                 pd_n,
  input wire logic                 bw,
  input wire logic                 pen,
  input wire logic [`FBCP_AW-1:0]  a,
  input wire logic [`FBCP_DW-1:0]  d,
  output logic     [`FBCP_DW-1:0]  dv,
  output logic     [`FBCP_DW-1:0]  drv,
  output wire logic                busy_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mode_q = 8'hff;
  logic [7:0] last_q = 8'hff;
  logic       busy_q = 1'b0;
  logic [7:0] idc;
  event       go;
  wire sel = pd_n && (cs2 ? !(cs1 && cs0) : !(cs1 || cs0));
  wire rd = sel && !oe_n && we_n;
  assign busy_drv = busy_q;
  always_comb
    case (a[2:1])
      2'h0: idc = MK;
      2'h1: idc = PT;
      2'h2: idc = {7'h0, a[17]};
      default: idc = 8'h00;
    endcase
  // Whichever comes first: strobe rise or deselect with strobe low
  always @(posedge we_n or negedge sel)
    if ((sel || !we_n) && !busy_q)
    begin
      if (last_q == 8'h40 || last_q == 8'h10)
      begin
        mode_q = 8'h70;
        last_q = 8'hff;
        if (pen)
          -> go;
      end
      else
      begin
        mode_q = d[7:0];
        last_q = d[7:0];
      end
    end
  always @go
  begin
    busy_q = 1'b1;
    #600 busy_q = 1'b0;
  end
  always @(posedge pd_n)
    mode_q = 8'hff;
  always_comb
  begin
    if (busy_q || mode_q == 8'h70)
      dv = {8'h00, ~busy_q, 7'h00};
    else if (mode_q == 8'h90)
      dv = {8'h00, idc};
    else
      dv = {~a[7:0], a[7:0]};
    drv = !rd ? 16'h0 : busy_q ? 16'h0080 : bw ? 16'hffff : 16'h00ff;
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Bench for the flash host: AHB-Lite register tasks against a
// behavioural flash on the pins; busy status has a pull-up.
`default_nettype none
`include "fbcp_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] WR = 32'h1 << `FBCP_CTRL_WRITE;
  localparam logic [31:0] ID = 32'h1 << `FBCP_CTRL_IDENT;
  localparam logic [31:0] WD = 32'h1 << `FBCP_CTRL_WORD;
  localparam logic [31:0] PN = 32'h1 << `FBCP_CTRL_PEN;
  localparam logic [31:0] RS = 32'h1 << `FBCP_CTRL_RESET;
  localparam logic [7:0]  MK = 8'h5a;
  localparam logic [7:0]  PT = 8'h3c;
  logic mclk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] pat = 16'ha5c3;
  wire [31:0] hrdata;
  wire hrdy, hresp, irq, cs0, cs1, cs2, oe_n, we_n, pd_n, bw, pen, dq_oe;
  wire busy_drv;
  wire [`FBCP_AW-1:0] addr;
  wire [`FBCP_DW-1:0] dq_o, dv, drv;
  int err_total = 0, n_tests = 0;
  // Undriven lanes toggle so a stale value never passes
  wire [`FBCP_DW-1:0] dq_i = dq_oe ? dq_o : (dv & drv) | (pat & ~drv);
  wire busy_pin = !busy_drv;
  fbcp_host i_fbcp_host (.mclk(mclk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy),
    .hresp(hresp), .irq(irq), .chip_select_0(cs0), .chip_select_1(cs1),
    .chip_select_2(cs2), .oe_n(oe_n), .we_n(we_n),
    .reset_powerdown_n(pd_n), .byte_wide(bw),
    .program_enable_supply(pen), .addr(addr), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i), .busy_status_output(busy_pin));
  fbcp_flash_mdl #(.MK(MK), .PT(PT)) i_fbcp_flash_mdl (.cs0(cs0),
    .cs1(cs1), .cs2(cs2), .oe_n(oe_n), .we_n(we_n), .pd_n(pd_n),
    .bw(bw), .pen(pen), .a(addr), .d(dq_o), .dv(dv), .drv(drv),
    .busy_drv(busy_drv));
  initial
    forever #5 mclk = ~mclk;
  always @(posedge mclk)
    pat <= ~pat;
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int i;
    i = 0;
    do
    begin
      rd(a);
      i++;
    end while (q[b] !== v && i < 2000);
    if (i == 2000)
      chk("poll", {31'h0, v}, {31'h0, q[b]});
  endtask
  task automatic cyc(input logic [31:0] c, a, d);
    wr(`FBCP_OFS_ADDR, a);
    wr(`FBCP_OFS_WDATA, d);
    wr(`FBCP_OFS_CTRL, c | 32'h1);
    poll(`FBCP_OFS_STAT, 1, 1'b0);
  endtask
  task automatic fr(input string nm, input logic [31:0] c, a, e);
    cyc(c, a, 32'h0);
    rd(`FBCP_OFS_RDATA);
    chk(nm, e, q);
  endtask
  task automatic irqc(input logic e);
    #1 chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    chk("watchdog", 32'h0, 32'h1);
    conclude;
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(`FBCP_OFS_STAT);
    chk("stat", 32'h4, q);
    rd(8'h1c);
    chk("unmapped", 32'h0, q);
    chk("hresp", 32'h0, {31'h0, hresp});
    irqc(1'b0);
    fr("array16", WD, 32'h12, 32'hed12);
    fr("array8", 0, 32'h12, 32'h12);
    $display("test reset and array done");
    cyc(WR | WD, 0, 32'h90);
    fr("maker", ID | WD, 1, MK);
    fr("part", ID | WD, 2, PT);
    fr("lock0", ID | WD, 5, 0);
    fr("lock1", ID | WD, 32'h20004, 1);
    fr("master", ID | WD, 7, 0);
    $display("test identifier done");
    cyc(WR | WD, 32'h40, 32'h40);
    cyc(WR | WD, 32'h40, 32'h1234);
    rd(`FBCP_OFS_STAT);
    chk("stat_lockout", 32'h4, q);
    fr("status_lockout", WD, 0, 32'h80);
    $display("test lockout done");
    wr(`FBCP_OFS_IRQ_STAT, 32'h7);
    cyc(WR | WD | PN, 32'h40, 32'h40);
    cyc(WR | WD | PN, 32'h40, 32'h1234);
    fr("status_busy", WD | PN, 0, 32'h0);
    rd(`FBCP_OFS_STAT);
    chk("stat_busy", 32'h0, q);
    poll(`FBCP_OFS_IRQ_STAT, 1, 1'b1);
    chk("irq_stat", 32'h3, q);
    irqc(1'b0);
    wr(`FBCP_OFS_IRQ_MASK, 32'h2);
    irqc(1'b1);
    wr(`FBCP_OFS_IRQ_STAT, 32'h2);
    irqc(1'b0);
    fr("status_done", WD | PN, 0, 32'h80);
    $display("test program done");
    wr(`FBCP_OFS_IRQ_STAT, 32'h7);
    cyc(RS, 0, 0);
    rd(`FBCP_OFS_IRQ_STAT);
    chk("irq_reset", 32'h4, q);
    fr("array_reset", WD, 32'h12, 32'hed12);
    cyc(WR | WD, 0, 32'h70);
    fr("status_reset", WD, 0, 32'h80);
    $display("test reset pulse done");
    conclude;
  end
endmodule
`default_nettype wire
